// file: design/hsp_oc_monitor.sv
`timescale 1ns/1ns
module hsp_oc_monitor (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] oc_n,
	input  wire logic [1:0] clear,
	output logic      [1:0] oc_live,
	output logic      [1:0] oc_sticky
);
	import hsp_pkg::*;

	logic [1:0] live_q, live_d;
	logic [1:0] sticky_q, sticky_d;

	always_comb begin
		live_d   = ~oc_n;
		sticky_d = live_d | (sticky_q & ~clear);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_q   <= 2'h0;
			sticky_q <= 2'h0;
		end else begin
			live_q   <= live_d;
			sticky_q <= sticky_d;
		end
	end

	assign oc_live   = live_q;
	assign oc_sticky = sticky_q;

	a_oc_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(oc_n != 2'h3) |=> ((sticky_q & ~$past(oc_n)) == ~$past(oc_n)))
		else $error("over-current event lost against clear");

endmodule : hsp_oc_monitor

// file: design/hsp_pkg.sv
package hsp_pkg;

	// Clock and strap timing
	localparam int          CLK_MHZ        = 125;
	localparam int          STRAP_HOLD_NS  = 100;
	localparam logic [7:0]  STRAP_HOLD_CYC =
		8'((STRAP_HOLD_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0]  HOLD_CNT_RST   = 8'h00;
	localparam logic [7:0]  HOLD_CNT_ONE   = 8'h01;

	// Register byte offsets
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_STRAP      = 8'h04;
	localparam logic [7:0]  REG_OC         = 8'h08;
	localparam logic [7:0]  REG_STATE      = 8'h0C;

	// Reset values
	localparam logic [1:0]  CTRL_RST       = 2'h3;
	localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

	// Field positions
	localparam int          CTRL_PWR_LSB   = 0;
	localparam int          STRAP_DIS_LSB  = 0;
	localparam int          STRAP_CHG_BIT  = 2;
	localparam int          STRAP_FIX_LSB  = 3;
	localparam int          STRAP_RSV_BIT  = 5;
	localparam int          STRAP_CFG_BIT  = 6;
	localparam int          STRAP_CODE_LSB = 8;
	localparam int          OC_LIVE_LSB    = 0;
	localparam int          OC_STICKY_LSB  = 4;

	// Configuration method that enables the port-disable straps
	localparam logic        CFG_STRAP_MODE = 1'h0;

	// Fixed-port codes
	localparam logic [1:0]  FIX_NONE       = 2'h0;
	localparam logic [1:0]  FIX_PORT1      = 2'h1;
	localparam logic [1:0]  FIX_BOTH       = 2'h2;
	localparam logic [1:0]  FIX_RSVD       = 2'h3;

	typedef enum logic [1:0] {
		ST_SAMPLE = 2'h0,
		ST_HOLD   = 2'h1,
		ST_RUN    = 2'h3
	} hsp_state_t;

	// Per-port mask of fixed ports; reserved code gives none
	function automatic logic [1:0] hsp_fixed_mask(input logic [1:0] code);
		case (code)
			FIX_PORT1: hsp_fixed_mask = 2'h1;
			FIX_BOTH:  hsp_fixed_mask = 2'h3;
			default:   hsp_fixed_mask = 2'h0;
		endcase
	endfunction : hsp_fixed_mask

endpackage : hsp_pkg

// file: design/hsp_strap_latch.sv
`timescale 1ns/1ns
module hsp_strap_latch (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       capture,
	input  wire logic [1:0] dis_pos,
	input  wire logic [1:0] dis_neg,
	input  wire logic       chg_pin,
	input  wire logic [1:0] fix_pins,
	input  wire logic       cfg_pin,
	output logic      [1:0] port_disabled,
	output logic            charging_support,
	output logic      [1:0] fixed_code,
	output logic            cfg_method
);
	import hsp_pkg::*;

	logic [1:0] dis_q, dis_d;
	logic       chg_q, chg_d;
	logic [1:0] fix_q, fix_d;
	logic       cfg_q, cfg_d;

	// Values are taken once and then held until the next reset
	always_comb begin
		dis_d = dis_q;
		chg_d = chg_q;
		fix_d = fix_q;
		cfg_d = cfg_q;
		if (capture) begin
			cfg_d = cfg_pin;
			dis_d = (cfg_pin == CFG_STRAP_MODE) ? (dis_pos & dis_neg) : 2'h0;
			chg_d = chg_pin;
			fix_d = fix_pins;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dis_q <= 2'h0;
			chg_q <= 1'h0;
			fix_q <= FIX_NONE;
			cfg_q <= 1'h0;
		end else begin
			dis_q <= dis_d;
			chg_q <= chg_d;
			fix_q <= fix_d;
			cfg_q <= cfg_d;
		end
	end

	assign port_disabled    = dis_q;
	assign charging_support = chg_q;
	assign fixed_code       = fix_q;
	assign cfg_method       = cfg_q;

endmodule : hsp_strap_latch

// file: design/hsp_strap_port_power.sv
`timescale 1ns/1ns
// Contract
// - Sample port data pins when straps enabled
// - Power enables drive active high
// - Port 1 power pin sampled as charging
// - Pull-down held until strap hold ends
// - Over-current inputs active low
// - Two fixed-port pins sampled together
// - Decode fixed-port code 00/01/10/11
// - Configuration select latched at reset release
module hsp_strap_port_power (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        port1_disable_strap_pos,
	input  wire logic        port1_disable_strap_neg,
	input  wire logic        port2_disable_strap_pos,
	input  wire logic        port2_disable_strap_neg,
	input  wire logic        port1_power_enable_i,
	output logic             port1_power_enable_o,
	output logic             port1_power_enable_oe,
	output logic             port1_charging_pulldown_en,
	output logic             port2_power_enable,
	input  wire logic        port1_overcurrent_n,
	input  wire logic        port2_overcurrent_n,
	input  wire logic        fixed_port_strap_hi,
	input  wire logic        fixed_port_strap_lo,
	input  wire logic        mgmt_bus_clock,
	output logic      [1:0]  port_disabled,
	output logic             charging_support,
	output logic      [1:0]  fixed_port_mask,
	output logic             fixed_code_reserved,
	output logic             cfg_method,
	output logic      [1:0]  overcurrent_flag
);
	import hsp_pkg::*;

	hsp_state_t  state_q, state_d;
	logic [7:0]  hold_cnt_q, hold_cnt_d;
	logic [1:0]  ctrl_q, ctrl_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pwr1_q, pwr1_d;
	logic        pwr1_oe_q, pwr1_oe_d;
	logic        pwr2_q, pwr2_d;
	logic        pdn_q, pdn_d;
	logic [1:0]  fixed_code;
	logic [1:0]  oc_sticky;
	logic [1:0]  oc_clear;
	logic        capture;
	logic        setup_ph;
	logic        access_ph;
	logic        addr_hit;
	logic        wr_en;
	logic [31:0] rd_value;

	assign capture = (state_q == ST_SAMPLE);

	hsp_strap_latch u_straps (
		.pclk             (pclk),
		.presetn          (presetn),
		.capture          (capture),
		.dis_pos          ({port2_disable_strap_pos, port1_disable_strap_pos}),
		.dis_neg          ({port2_disable_strap_neg, port1_disable_strap_neg}),
		.chg_pin          (port1_power_enable_i),
		.fix_pins         ({fixed_port_strap_hi, fixed_port_strap_lo}),
		.cfg_pin          (mgmt_bus_clock),
		.port_disabled    (port_disabled),
		.charging_support (charging_support),
		.fixed_code       (fixed_code),
		.cfg_method       (cfg_method)
	);

	hsp_oc_monitor u_oc (
		.pclk      (pclk),
		.presetn   (presetn),
		.oc_n      ({port2_overcurrent_n, port1_overcurrent_n}),
		.clear     (oc_clear),
		.oc_live   (overcurrent_flag),
		.oc_sticky (oc_sticky)
	);

	assign fixed_port_mask     = hsp_fixed_mask(fixed_code);
	assign fixed_code_reserved = (fixed_code == FIX_RSVD);

	// Strap sampling, hold and run sequence
	always_comb begin
		state_d    = state_q;
		hold_cnt_d = hold_cnt_q;
		case (state_q)
			ST_SAMPLE: begin
				state_d    = ST_HOLD;
				hold_cnt_d = HOLD_CNT_RST;
			end
			ST_HOLD: begin
				hold_cnt_d = hold_cnt_q + HOLD_CNT_ONE;
				if (hold_cnt_q == STRAP_HOLD_CYC - HOLD_CNT_ONE) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_SAMPLE;
			hold_cnt_q <= HOLD_CNT_RST;
		end else begin
			state_q    <= state_d;
			hold_cnt_q <= hold_cnt_d;
		end
	end

	// Port power pins
	always_comb begin
		pdn_d     = (state_d != ST_RUN);
		pwr1_oe_d = (state_d == ST_RUN);
		pwr1_d    = pwr1_oe_d && ctrl_d[0] && !port_disabled[0];
		pwr2_d    = (state_d == ST_RUN) && ctrl_d[1] && !port_disabled[1];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pdn_q     <= 1'h1;
			pwr1_oe_q <= 1'h0;
			pwr1_q    <= 1'h0;
			pwr2_q    <= 1'h0;
		end else begin
			pdn_q     <= pdn_d;
			pwr1_oe_q <= pwr1_oe_d;
			pwr1_q    <= pwr1_d;
			pwr2_q    <= pwr2_d;
		end
	end

	assign port1_charging_pulldown_en = pdn_q;
	assign port1_power_enable_oe      = pwr1_oe_q;
	assign port1_power_enable_o       = pwr1_q;
	assign port2_power_enable         = pwr2_q;

	// APB slave, zero wait states, read data captured in setup
	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign addr_hit  = (paddr == REG_CTRL) || (paddr == REG_STRAP) ||
		(paddr == REG_OC) || (paddr == REG_STATE);
	assign pready    = 1'b1;
	assign pslverr   = access_ph && !addr_hit;
	assign wr_en     = access_ph && pwrite && addr_hit;
	assign oc_clear  = (wr_en && paddr == REG_OC) ?
		pwdata[OC_STICKY_LSB +: 2] : 2'h0;

	always_comb begin
		rd_value = 32'h0000_0000;
		case (paddr)
			REG_CTRL: begin
				rd_value[CTRL_PWR_LSB +: 2] = ctrl_q;
			end
			REG_STRAP: begin
				rd_value[STRAP_DIS_LSB +: 2]  = port_disabled;
				rd_value[STRAP_CHG_BIT]       = charging_support;
				rd_value[STRAP_FIX_LSB +: 2]  = fixed_port_mask;
				rd_value[STRAP_RSV_BIT]       = fixed_code_reserved;
				rd_value[STRAP_CFG_BIT]       = cfg_method;
				rd_value[STRAP_CODE_LSB +: 2] = fixed_code;
			end
			REG_OC: begin
				rd_value[OC_LIVE_LSB +: 2]   = overcurrent_flag;
				rd_value[OC_STICKY_LSB +: 2] = oc_sticky;
			end
			REG_STATE: begin
				rd_value[1:0] = state_q;
			end
			default: begin
				rd_value = 32'h0000_0000;
			end
		endcase
	end

	always_comb begin
		ctrl_d   = ctrl_q;
		prdata_d = prdata_q;
		if (wr_en && paddr == REG_CTRL) begin
			ctrl_d = pwdata[CTRL_PWR_LSB +: 2];
		end
		if (setup_ph) begin
			prdata_d = pwrite ? RDATA_RST : rd_value;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= CTRL_RST;
			prdata_q <= RDATA_RST;
		end else begin
			ctrl_q   <= ctrl_d;
			prdata_q <= prdata_d;
		end
	end

	assign prdata = prdata_q;

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Checked one cycle after the capture edge, so reset release cannot race it
	a_port_disable: assert property (
		$rose(state_q == ST_HOLD) |->
			port_disabled == ($past(mgmt_bus_clock) == CFG_STRAP_MODE ?
			$past({port2_disable_strap_pos & port2_disable_strap_neg,
			port1_disable_strap_pos & port1_disable_strap_neg}) : 2'h0))
		else $error("port disable strap latched wrongly");

	a_disabled_no_power: assert property (
		port_disabled[1] |-> !port2_power_enable)
		else $error("disabled port 2 is powered");

	a_power_high: assert property (
		(state_q == ST_RUN && ctrl_q[1] && !port_disabled[1] && !pslverr) ##1
		(ctrl_q[1]) |-> port2_power_enable)
		else $error("port 2 power enable not driven high");

	a_charge_strap: assert property (
		$rose(state_q == ST_HOLD) |-> charging_support == $past(port1_power_enable_i))
		else $error("charging strap latched wrongly");

	a_pulldown_held: assert property (
		capture |-> (port1_charging_pulldown_en && !port1_power_enable_oe)[*8]
		##[1:60] (!port1_charging_pulldown_en && port1_power_enable_oe))
		else $error("pull-down not released after hold");

	a_oc_flag: assert property (
		!port1_overcurrent_n |=> overcurrent_flag[0])
		else $error("port 1 over-current not flagged");

	a_fixed_sample: assert property (
		$rose(state_q == ST_HOLD) |->
			fixed_code == $past({fixed_port_strap_hi, fixed_port_strap_lo}))
		else $error("fixed-port code latched wrongly");

	a_fixed_decode: assert property (
		(fixed_code == FIX_BOTH |-> fixed_port_mask == 2'h3) and
		(fixed_code == FIX_PORT1 |-> fixed_port_mask == 2'h1) and
		(fixed_code == FIX_NONE |-> fixed_port_mask == 2'h0))
		else $error("fixed-port decode wrong");

	a_cfg_latch: assert property (
		$rose(state_q == ST_HOLD) |-> cfg_method == $past(mgmt_bus_clock))
		else $error("configuration select latched wrongly");

	a_strap_stable: assert property (
		!capture |=> $stable(port_disabled) && $stable(charging_support) &&
		$stable(fixed_code) && $stable(cfg_method))
		else $error("strap value changed after release");

	a_pulldown_excl: assert property (
		port1_charging_pulldown_en |-> !port1_power_enable_oe)
		else $error("pull-down on while power pin driven");

	a_port1_power: assert property (
		(state_q == ST_RUN && ctrl_q[0] && !port_disabled[0]) ##1 ctrl_q[0]
		|-> port1_power_enable_o && port1_power_enable_oe)
		else $error("port 1 power enable not driven high");

	a_oc_flag2: assert property (
		!port2_overcurrent_n |=> overcurrent_flag[1])
		else $error("port 2 over-current not flagged");

	a_oc_idle: assert property (
		(port1_overcurrent_n && port2_overcurrent_n) |=> overcurrent_flag == 2'h0)
		else $error("over-current flagged on idle input");

	a_fixed_reserved: assert property (
		fixed_code == FIX_RSVD |-> fixed_port_mask == 2'h0 && fixed_code_reserved)
		else $error("reserved fixed-port code decoded wrongly");

	a_ctrl_write: assert property (
		wr_en && paddr == REG_CTRL |=> ctrl_q == $past(pwdata[CTRL_PWR_LSB +: 2]))
		else $error("power request write lost");

	c_reach_run: cover property (state_q == ST_HOLD ##1 state_q == ST_RUN);
	c_charging:  cover property (charging_support && port1_power_enable_oe);
	c_oc_event:  cover property (!port2_overcurrent_n ##1 overcurrent_flag[1]);
	c_disabled:  cover property (capture ##1 port_disabled != 2'h0);
	c_ctrl_wr:   cover property (wr_en && paddr == REG_CTRL);

endmodule : hsp_strap_port_power

// file: testbench/hsp_board_model.sv
`timescale 1ns/1ns
module hsp_board_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:0] straps,
	input  wire logic [1:0] oc_req,
	input  wire logic       pwr1_o,
	input  wire logic       pwr1_oe,
	output logic      [3:0] data_pins,
	output logic            pwr1_pin,
	output logic      [1:0] fix_pins,
	output logic            cfg_pin,
	output logic      [1:0] oc_n
);
	logic [3:0] traffic_q;
	logic [1:0] since_q;
	logic       straps_on;

	// Line activity after release changes every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			traffic_q <= 4'h0;
		else
			traffic_q <= traffic_q + 4'h5;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_q <= 2'h0;
		else if (since_q != 2'h3)
			since_q <= since_q + 2'h1;
	end
	// Strap levels stand through the capture edge and the edge after it
	assign straps_on = since_q < 2'h2;
	assign data_pins = straps_on ? straps[3:0] : traffic_q;
	assign fix_pins  = straps_on ? straps[6:5] : traffic_q[1:0];
	assign cfg_pin   = straps_on ? straps[7] : traffic_q[2];
	// Undriven pin falls to the pull-down once straps are gone
	assign pwr1_pin  = pwr1_oe ? pwr1_o : (straps_on & straps[4]);
	// Pull-up keeps an idle sense line high
	assign oc_n      = ~oc_req;
endmodule : hsp_board_model

// file: testbench/hsp_strap_port_power_test.sv
`timescale 1ns/1ns
module hsp_strap_port_power_test;
	import hsp_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, straps = 8'h00, r;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, p1o, p1oe, pd, p2, chg, rsv, cfg, err, p1pin, cfgp;
	logic [1:0]  dis, mask, ocf, fix, ocn, oc_req = 2'h0, ed;
	logic [3:0]  dp;
	int          mismatches = 0, total_checks = 0, seed = 31130, n;
	int          fix_tab[4] = '{0, 1, 3, 0};
	// Reset pulse of 1 us at 8 ns per cycle
	localparam int RST_CYC = 125;

	// Reference clock from the board
	always #4 pclk = ~pclk;

	hsp_strap_port_power u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port1_disable_strap_pos(dp[0]), .port1_disable_strap_neg(dp[1]),
		.port2_disable_strap_pos(dp[2]), .port2_disable_strap_neg(dp[3]),
		.port1_power_enable_i(p1pin), .port1_power_enable_o(p1o),
		.port1_power_enable_oe(p1oe), .port1_charging_pulldown_en(pd),
		.port2_power_enable(p2), .port1_overcurrent_n(ocn[0]),
		.port2_overcurrent_n(ocn[1]), .fixed_port_strap_hi(fix[1]),
		.fixed_port_strap_lo(fix[0]), .mgmt_bus_clock(cfgp),
		.port_disabled(dis), .charging_support(chg), .fixed_port_mask(mask),
		.fixed_code_reserved(rsv), .cfg_method(cfg), .overcurrent_flag(ocf));

	hsp_board_model u_board (.pclk(pclk), .presetn(presetn), .straps(straps),
		.oc_req(oc_req), .pwr1_o(p1o), .pwr1_oe(p1oe), .data_pins(dp),
		.pwr1_pin(p1pin), .fix_pins(fix), .cfg_pin(cfgp), .oc_n(ocn));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", what, e, g);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) begin
			chk("pready", 1, 0);
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	initial begin
		for (int k = 0; k < 8; k++) begin
			@(posedge pclk);
			r = 8'($random(seed));
			if (k[2])
				r = {k[0] ? 1'b1 : CFG_STRAP_MODE, r[6:4], 4'hF};
			straps <= {r[7], 2'(k), r[4:0]};
			presetn <= 1'b0;
			repeat (k == 0 ? 2 : RST_CYC) @(posedge pclk);
			presetn <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				#1;
				n++;
			end while (pd === 1'b1 && n < 40);
			chk("hold", 32'(STRAP_HOLD_CYC) + 1, n);
			if (n >= 40)
				complete_run();
			chk("oe", 1, p1oe);
			for (int i = 0; i < 2; i++)
				ed[i] = r[2 * i] & r[2 * i + 1] & (r[7] == CFG_STRAP_MODE);
			chk("disabled", ed, dis);
			chk("charging", r[4], chg);
			chk("mask", fix_tab[k % 4], mask);
			chk("reserved", k % 4 == 3, rsv);
			chk("cfg", r[7], cfg);
			chk("power", 2'(~ed), {p2, p1o});
			chk("pin", p1o, p1pin);
			apb(1'b0, REG_STRAP, 0);
			chk("strap reg", {k[1:0], 1'b0, r[7], k % 4 == 3, 2'(fix_tab[k % 4]),
				r[4], ed}, rd[9:0]);
			apb(1'b0, REG_STATE, 0);
			chk("state", 3, rd[1:0]);
			apb(1'b1, REG_CTRL, 32'(k % 4));
			repeat (2) @(posedge pclk);
			#1;
			chk("ctrl power", 2'(k) & ~ed, {p2, p1o});
			@(posedge pclk);
			oc_req <= r[6:5];
			repeat (3) @(posedge pclk);
			#1;
			chk("oc flag", r[6:5], ocf);
			@(posedge pclk);
			oc_req <= 2'h0;
			repeat (2) @(posedge pclk);
			apb(1'b0, REG_OC, 0);
			chk("oc reg", {r[6:5], 4'h0}, rd[5:0]);
			apb(1'b1, REG_OC, 32'h30);
			apb(1'b0, REG_OC, 0);
			chk("oc clear", 0, rd[5:0]);
			apb(1'b0, 8'h10, 0);
			chk("unmapped err", 1, err);
			chk("unmapped data", 0, rd);
		end
		complete_run();
	end
endmodule : hsp_strap_port_power_test
